// ### usb_irq_consts.vh
// Register map, field positions and reset values for the interrupt enable and wakeup status bank
`ifndef USB_IRQ_CONSTS_VH
`define USB_IRQ_CONSTS_VH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define OFS_SRC_ENABLES   8'h98
`define OFS_TX_TUNING     8'h9C
`define OFS_WAKE_STATUS   8'hA8
`define OFS_IRQ_STATUS    8'hC0
`define OFS_IRQ_ENABLE    8'hC4
`define OFS_IRQ_CLEAR     8'hC8

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_ALWAYS_ON     31
`define BIT_TX_OFF        19
`define BIT_RX_OFF        18
`define BIT_PHY           17
`define BIT_DATA_PORT     16
`define BIT_MAC_FAULT     15
`define BIT_UNDERRUN      14
`define BIT_OVERRUN       13
`define BIT_FRAME_PEND    12
`define GPIO_COUNT        12
`define BIT_DEV_WAKE      20
`define BIT_FUNC_WAKE     19
`define BIT_DEV_WAKE_CHG  4
`define BIT_FUNC_WAKE_CHG 3
`define TUNING_WIDTH      7

// ------------------------------------------------------------
// Reset values and masks
// ------------------------------------------------------------
`define SRC_ENABLE_MASK   32'h800F_FFFF
`define SRC_ENABLE_RESET  32'h0000_0000
`define TUNING_ZERO       7'h00
`define IRQ_COUNT         2

`endif

// ### usb_irq_enable_and_wakeup_status.v
// Interrupt source enables, transmit tuning and wakeup status registers on Avalon-MM
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`include "usb_irq_consts.vh"

module usb_irq_enable_and_wakeup_status
(
   // Clock and reset
   input  wire        mclk,
   input  wire        resetn,
   // Avalon-MM slave
   input  wire [7:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [3:0]  byteenable,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   // Event sources from the device core
   input  wire        transmitterOffEvent,
   input  wire        receiverOffEvent,
   input  wire        phyEvent,
   input  wire        dataPortEvent,
   input  wire        macFaultEvent,
   input  wire        txUnderrunEvent,
   input  wire        txOverrunEvent,
   input  wire        frameePendingEvent,
   input  wire [11:0] gpioEvent,
   // Interrupt endpoint packet timing
   input  wire        intervalTick,
   output reg         sendIntPacket,
   output wire [31:0] gatedSources,
   output wire        usbStatusIrq,
   // Wakeup state from the USB device core
   input  wire        deviceWakeupEnabled,
   input  wire        functionWakeupCapable,
   // Tuning image load and restore
   input  wire        imageLoad,
   input  wire        eepromPresent,
   input  wire [6:0]  eepromTuning,
   input  wire        otpProgrammed,
   input  wire [6:0]  otpTuning,
   input  wire        usbReset,
   input  wire        liteReset,
   // Transmit tuning to the serdes
   output wire        txSwing,
   output wire [2:0]  txMargin,
   output wire [1:0]  txDeemphasis,
   output wire        elasticityBufferMode,
   // Block interrupt
   output wire        irq
);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg  [31:0] srcEnable_reg;
   reg  [6:0]  tuning_reg;
   reg  [6:0]  image_reg;
   reg         devWakeChg_reg;
   reg         funcWakeChg_reg;
   reg  [1:0]  devWakeSync_reg;
   reg  [1:0]  funcWakeSync_reg;
   reg         devWakePrev_reg;
   reg         funcWakePrev_reg;
   reg  [1:0]  irqStatus_reg;
   reg  [1:0]  irqEnable_reg;
   reg         readDone_reg;

   wire        wrEn;
   wire        devWakeNow;
   wire        funcWakeNow;
   wire        devWakeEdge;
   wire        funcWakeEdge;
   wire [31:0] eventVec;
   wire [31:0] wakeStatus;
   wire [6:0]  loadImage;
   wire [31:0] byteMask;
   wire [1:0]  irqEvents;
   wire        anyEnabledEvent;
   wire        packetCause;
   wire        wrSrcEnable;
   wire        wrTuning;
   wire        wrWakeStatus;
   wire        wrIrqEnable;
   wire        wrIrqClear;
   wire [31:0] srcEnable_next;

   // Next values of the clocked registers
   reg         devWakeChg_next;
   reg         funcWakeChg_next;
   reg  [6:0]  tuning_next;
   reg  [6:0]  image_next;
   reg  [1:0]  irqStatus_next;
   reg  [31:0] readdata_next;

   // Writes finish in one cycle; reads wait one cycle for registered data
   assign waitrequest = read & ~readDone_reg;
   assign wrEn        = write;
   assign byteMask    = {{8{byteenable[3]}}, {8{byteenable[2]}},
                         {8{byteenable[1]}}, {8{byteenable[0]}}};

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   // Narrow registers live in lane 0, so only the enables look at all lanes
   assign wrSrcEnable  = wrEn & (address == `OFS_SRC_ENABLES);
   assign wrTuning     = wrEn & (address == `OFS_TX_TUNING) & byteenable[0];
   assign wrWakeStatus = wrEn & (address == `OFS_WAKE_STATUS) & byteenable[0];
   assign wrIrqEnable  = wrEn & (address == `OFS_IRQ_ENABLE) & byteenable[0];
   assign wrIrqClear   = wrEn & (address == `OFS_IRQ_CLEAR) & byteenable[0];

   // ------------------------------------------------------------
   // Event gating
   // ------------------------------------------------------------
   // Event vector lines up bit for bit with the enable register
   assign eventVec = {12'h000,
                      transmitterOffEvent,
                      receiverOffEvent,
                      phyEvent,
                      dataPortEvent,
                      macFaultEvent,
                      txUnderrunEvent,
                      txOverrunEvent,
                      frameePendingEvent,
                      gpioEvent};

   // Per-bit gate; a zero enable blocks its event
   genvar gi;
   generate
      for (gi = 0; gi < 20; gi = gi + 1)
      begin : gateBit
         assign gatedSources[gi] = eventVec[gi] & srcEnable_reg[gi];
      end
   endgenerate
   assign gatedSources[31:20] = 12'h000;
   assign anyEnabledEvent     = |gatedSources;

   // Always-on forces a packet even when no enabled source fired
   assign packetCause = srcEnable_reg[`BIT_ALWAYS_ON] | anyEnabledEvent;

   // One packet per interval, and only when there is a cause
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         sendIntPacket <= 1'b0;
      else
         sendIntPacket <= intervalTick & packetCause;
   end

   // ------------------------------------------------------------
   // Wakeup state synchronisers and change detection
   // ------------------------------------------------------------
   // Core state may come from the USB clock, so two stages first
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         devWakeSync_reg  <= 2'b00;
         funcWakeSync_reg <= 2'b00;
      end
      else
      begin
         devWakeSync_reg  <= {devWakeSync_reg[0], deviceWakeupEnabled};
         funcWakeSync_reg <= {funcWakeSync_reg[0], functionWakeupCapable};
      end
   end

   // Last synchronised level; reset matches the idle pin, so no false edge
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         devWakePrev_reg  <= 1'b0;
         funcWakePrev_reg <= 1'b0;
      end
      else
      begin
         devWakePrev_reg  <= devWakeNow;
         funcWakePrev_reg <= funcWakeNow;
      end
   end

   assign devWakeNow   = devWakeSync_reg[1];
   assign funcWakeNow  = funcWakeSync_reg[1];
   assign devWakeEdge  = devWakeNow ^ devWakePrev_reg;
   assign funcWakeEdge = funcWakeNow ^ funcWakePrev_reg;

   // Next flag values; a new change beats a same-cycle clear
   always @*
   begin
      devWakeChg_next  = devWakeChg_reg;
      funcWakeChg_next = funcWakeChg_reg;
      if (devWakeEdge)
         devWakeChg_next = 1'b1;
      else if (wrWakeStatus && writedata[`BIT_DEV_WAKE_CHG])
         devWakeChg_next = 1'b0;
      if (funcWakeEdge)
         funcWakeChg_next = 1'b1;
      else if (wrWakeStatus && writedata[`BIT_FUNC_WAKE_CHG])
         funcWakeChg_next = 1'b0;
   end

   // Sticky change flags, cleared only by power-on reset or software
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         devWakeChg_reg  <= 1'b0;
         funcWakeChg_reg <= 1'b0;
      end
      else
      begin
         devWakeChg_reg  <= devWakeChg_next;
         funcWakeChg_reg <= funcWakeChg_next;
      end
   end

   // Status view: change bits low, live mirrors high
   assign wakeStatus = {11'h000,
                        devWakeNow,
                        funcWakeNow,
                        14'h0000,
                        devWakeChg_reg,
                        funcWakeChg_reg,
                        3'b000};
   assign usbStatusIrq = |wakeStatus[15:0];

   // ------------------------------------------------------------
   // Transmit tuning with image restore
   // ------------------------------------------------------------
   // EEPROM wins over OTP; an unprogrammed OTP gives zero
   assign loadImage = eepromPresent ? eepromTuning :
                      (otpProgrammed ? otpTuning : `TUNING_ZERO);

   // Load beats restore, and restore beats a software write
   always @*
   begin
      image_next  = image_reg;
      tuning_next = tuning_reg;
      if (imageLoad)
      begin
         image_next  = loadImage;
         tuning_next = loadImage;
      end
      else if (usbReset || liteReset)
         tuning_next = image_reg;
      else if (wrTuning)
         tuning_next = writedata[6:0];
   end

   // Only the power-on reset clears these; USB and lite resets restore
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         image_reg  <= `TUNING_ZERO;
         tuning_reg <= `TUNING_ZERO;
      end
      else
      begin
         image_reg  <= image_next;
         tuning_reg <= tuning_next;
      end
   end

   assign txSwing              = tuning_reg[6];
   assign txMargin             = tuning_reg[5:3];
   assign txDeemphasis         = tuning_reg[2:1];
   assign elasticityBufferMode = tuning_reg[0];

   // ------------------------------------------------------------
   // Source enables and block interrupt registers
   // ------------------------------------------------------------
   // Lanes merge into the old value; reserved bits stay zero
   assign srcEnable_next = ((srcEnable_reg & ~byteMask) | (writedata & byteMask))
                           & `SRC_ENABLE_MASK;

   // Enables are plain read/write and clear on power-on reset only
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         srcEnable_reg <= `SRC_ENABLE_RESET;
      else if (wrSrcEnable)
         srcEnable_reg <= srcEnable_next;
   end

   // Block interrupt: bit 0 wakeup change, bit 1 enabled source event
   assign irqEvents = {anyEnabledEvent, devWakeEdge | funcWakeEdge};

   // Set beats clear in the same cycle, so no event is lost
   always @*
   begin
      irqStatus_next = irqStatus_reg | irqEvents;
      if (wrIrqClear)
         irqStatus_next = (irqStatus_reg & ~writedata[1:0]) | irqEvents;
   end

   // Enable and sticky status of the block interrupt
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         irqStatus_reg <= 2'b00;
         irqEnable_reg <= 2'b00;
      end
      else
      begin
         if (wrIrqEnable)
            irqEnable_reg <= writedata[1:0];
         irqStatus_reg <= irqStatus_next;
      end
   end

   assign irq = |(irqStatus_reg & irqEnable_reg);

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // Read mux; unmapped addresses and the write-only clear read zero
   always @*
   begin
      readdata_next = 32'h0000_0000;
      case (address)
         `OFS_SRC_ENABLES: readdata_next = srcEnable_reg;
         `OFS_TX_TUNING:   readdata_next = {25'h000_0000, tuning_reg};
         `OFS_WAKE_STATUS: readdata_next = wakeStatus;
         `OFS_IRQ_STATUS:  readdata_next = {30'h0000_0000, irqStatus_reg};
         `OFS_IRQ_ENABLE:  readdata_next = {30'h0000_0000, irqEnable_reg};
         default:          readdata_next = 32'h0000_0000;
      endcase
   end

   // Registered read data costs one wait state but keeps the bus glitch free
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         readdata     <= 32'h0000_0000;
         readDone_reg <= 1'b0;
      end
      else
      begin
         readDone_reg <= read & ~readDone_reg;
         readdata     <= readdata_next;
      end
   end

endmodule // usb_irq_enable_and_wakeup_status

// ### usb_irq_enable_and_wakeup_status_sva.sv
// Concurrent checks on the interrupt enable and wakeup status bank ports
`timescale 1ns/1ns
module usb_irq_sva
(
   // Clock and reset
   input logic        mclk,
   input logic        resetn,
   // Bus handshake
   input logic        read,
   input logic        write,
   input logic        waitrequest,
   // Sources and packets
   input logic [11:0] gpioEvent,
   input logic [31:0] gatedSources,
   input logic        intervalTick,
   input logic        sendIntPacket,
   input logic        usbStatusIrq,
   // Tuning image
   input logic        imageLoad,
   input logic        eepromPresent,
   input logic [6:0]  eepromTuning,
   input logic        otpProgrammed,
   input logic [6:0]  otpTuning,
   input logic        usbReset,
   input logic        txSwing,
   input logic [2:0]  txMargin,
   input logic [1:0]  txDeemphasis,
   input logic        elasticityBufferMode
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Packed tuning value, same order as the register
   wire [6:0] tune = {txSwing, txMargin, txDeemphasis, elasticityBufferMode};
   // --------------------------------------------------------------
   // Load and restore steps
   // --------------------------------------------------------------
   sequence seqEe;
      imageLoad && eepromPresent;
   endsequence
   sequence seqOtp;
      imageLoad && !eepromPresent && otpProgrammed;
   endsequence
   sequence seqHeld;
      usbReset && !imageLoad ##1 usbReset && !imageLoad;
   endsequence
   AST_WR_NOWAIT: assert property (write |-> !waitrequest)
      else $error("write stalled");
   AST_RD_ONEWAIT: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
      else $error("read wait wrong");
   AST_GATE_GPIO: assert property ((gatedSources[11:0] & ~gpioEvent) == 12'h000)
      else $error("gpio source passed without event");
   AST_GATE_HIGH: assert property (gatedSources[31:20] == 12'h000)
      else $error("unused source bits set");
   AST_PKT_CAUSE: assert property (sendIntPacket |-> $past(intervalTick))
      else $error("packet without interval");
   AST_PKT_SRC: assert property (intervalTick && gatedSources != 0 |=> sendIntPacket)
      else $error("enabled event sent no packet");
   AST_LOAD_EE: assert property (seqEe |=> tune == $past(eepromTuning))
      else $error("eeprom image not loaded");
   AST_LOAD_OTP: assert property (seqOtp |=> tune == $past(otpTuning))
      else $error("otp image not loaded");
   AST_LOAD_ZERO: assert property (imageLoad && !eepromPresent && !otpProgrammed |=> tune == 7'h00)
      else $error("empty image not zero");
   AST_RESTORE: assert property (seqHeld |=> $stable(tune))
      else $error("tuning moved during restore");
   AST_STS_STICKY: assert property (usbStatusIrq && !write |=> usbStatusIrq)
      else $error("status irq dropped unasked");
endmodule // usb_irq_sva

bind usb_irq_enable_and_wakeup_status usb_irq_sva u_sva (.mclk, .resetn, .read, .write,
   .waitrequest, .gpioEvent, .gatedSources, .intervalTick, .sendIntPacket, .usbStatusIrq,
   .imageLoad, .eepromPresent, .eepromTuning, .otpProgrammed, .otpTuning, .usbReset,
   .txSwing, .txMargin, .txDeemphasis, .elasticityBufferMode);

// ### usb_irq_enable_and_wakeup_status_tb_top.sv
// Self-checking bench for the interrupt enable and wakeup status bank
`timescale 1ns/1ns
module usb_irq_enable_and_wakeup_status_tb_top;
   // --------------------------------------------------------------
   // Signals
   // --------------------------------------------------------------
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  address = 8'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [3:0]  byteenable = 4'hF;
   logic [31:0] writedata = 32'h0000_0000;
   logic [19:0] ev = 20'h0_0000;
   logic        tick = 1'b0, devWake = 1'b0, funcWake = 1'b0;
   logic        load = 1'b0, eePres = 1'b0, otpProg = 1'b0, usbRst = 1'b0, liteRst = 1'b0;
   logic [6:0]  eeTune = 7'h00, otpTune = 7'h00, img;
   wire  [31:0] readdata, gatedSources;
   wire         waitrequest, sendIntPacket, usbStatusIrq, irq;
   wire  [6:0]  tune;
   logic [31:0] expQ[$], v;
   logic [7:0]  rstAddr[6] = '{8'h98, 8'h9C, 8'hA8, 8'hC0, 8'hC4, 8'h00};
   int          badCount = 0, nChecks = 0, k;

   usb_irq_enable_and_wakeup_status DUT (.mclk(mclk), .resetn(resetn), .address(address),
      .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .transmitterOffEvent(ev[19]),
      .receiverOffEvent(ev[18]), .phyEvent(ev[17]), .dataPortEvent(ev[16]),
      .macFaultEvent(ev[15]), .txUnderrunEvent(ev[14]), .txOverrunEvent(ev[13]),
      .frameePendingEvent(ev[12]), .gpioEvent(ev[11:0]), .intervalTick(tick),
      .sendIntPacket(sendIntPacket), .gatedSources(gatedSources), .usbStatusIrq(usbStatusIrq),
      .deviceWakeupEnabled(devWake), .functionWakeupCapable(funcWake), .imageLoad(load),
      .eepromPresent(eePres), .eepromTuning(eeTune), .otpProgrammed(otpProg),
      .otpTuning(otpTune), .usbReset(usbRst), .liteReset(liteRst), .txSwing(tune[6]),
      .txMargin(tune[5:3]), .txDeemphasis(tune[2:1]), .elasticityBufferMode(tune[0]), .irq(irq));

   // Free-running clock
   always #10 mclk = ~mclk;

   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   task automatic giveVerdict;
      if (badCount == 0 && nChecks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nChecks++;
      if (e !== g)
      begin
         badCount++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Returns at the rising edge at which waitrequest is sampled low
   task automatic waitLow;
      int n;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 20);
      if (n >= 20)
      begin
         badCount++;
         giveVerdict();
      end
   endtask
   task automatic busWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge mclk);
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= 1'b1;
      waitLow();
      write <= 1'b0;
   endtask
   task automatic busRd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      address <= a;
      read <= 1'b1;
      expQ.push_back(e);
      waitLow();
      read <= 1'b0;
   endtask
   task automatic pulseTick(input logic e);
      @(posedge mclk);
      tick <= 1'b1;
      @(posedge mclk);
      tick <= 1'b0;
      @(negedge mclk);
      chk("sendIntPacket", {31'h0, e}, {31'h0, sendIntPacket});
      @(posedge mclk);
   endtask

   // Read monitor takes the oldest expectation at each completed read
   always @(posedge mclk)
      if (read && !waitrequest)
         chk("readdata", expQ.size() ? expQ.pop_front() : 32'hDEAD_BEEF, readdata);

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge mclk);
      badCount++;
      giveVerdict();
   end

   // Main sequence
   initial
   begin
      k = $urandom(56);
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      for (k = 0; k < 6; k++)
         busRd(rstAddr[k], 32'h0000_0000);
      v = $urandom & 32'h000F_FFFF;
      busWr(8'h98, v, 4'hF);
      busRd(8'h98, v);
      busWr(8'h98, 32'hFFFF_FFFF, 4'h2);
      busRd(8'h98, v | 32'h0000_FF00);
      busWr(8'h10, 32'hFFFF_FFFF, 4'hF);
      busRd(8'h10, 32'h0000_0000);
      // One source enabled at a time, then all but the firing one
      for (k = 0; k < 20; k++)
      begin
         ev <= 20'hF_FFFF;
         busWr(8'h98, 32'h1 << k, 4'hF);
         @(negedge mclk);
         chk("gatedSources", 32'h1 << k, gatedSources);
         pulseTick(1'b1);
         ev <= 20'h1 << k;
         busWr(8'h98, ~(32'h1 << k) & 32'h000F_FFFF, 4'hF);
         @(negedge mclk);
         chk("gatedSources", 32'h0, gatedSources);
         pulseTick(1'b0);
      end
      ev <= 20'h0_0000;
      busWr(8'h98, 32'h8000_0000, 4'hF);
      pulseTick(1'b1);
      busWr(8'h98, 32'h0000_0000, 4'hF);
      pulseTick(1'b0);
      // Wakeup change flags, mirrors and block interrupt
      busWr(8'hC8, 32'h0000_0003, 4'hF);
      devWake <= 1'b1;
      repeat (6) @(posedge mclk);
      busRd(8'hA8, 32'h0010_0010);
      chk("usbStatusIrq", 32'h1, {31'h0, usbStatusIrq});
      chk("irq", 32'h0, {31'h0, irq});
      busRd(8'hC0, 32'h0000_0001);
      busWr(8'hC4, 32'h0000_0001, 4'hF);
      repeat (3) @(negedge mclk);
      chk("irq", 32'h1, {31'h0, irq});
      busWr(8'hA8, 32'h0000_0010, 4'hF);
      busRd(8'hA8, 32'h0010_0000);
      chk("usbStatusIrq", 32'h0, {31'h0, usbStatusIrq});
      busWr(8'hC8, 32'h0000_0001, 4'hF);
      repeat (3) @(negedge mclk);
      chk("irq", 32'h0, {31'h0, irq});
      @(posedge mclk);
      funcWake <= 1'b1;
      repeat (6) @(posedge mclk);
      busRd(8'hA8, 32'h0018_0008);
      busWr(8'hA8, 32'h0000_0008, 4'hF);
      busRd(8'hA8, 32'h0018_0000);
      // Image sources in priority order, then overwrite and restore
      for (k = 0; k < 3; k++)
      begin
         @(posedge mclk);
         eeTune <= 7'($urandom);
         otpTune <= 7'($urandom);
         eePres <= (k == 0);
         otpProg <= (k < 2);
         load <= 1'b1;
         @(posedge mclk);
         load <= 1'b0;
         img = (k == 0) ? eeTune : (k == 1) ? otpTune : 7'h00;
         @(negedge mclk);
         chk("tune", {25'h0, img}, {25'h0, tune});
         busWr(8'h9C, {25'h0, ~img}, 4'h1);
         busRd(8'h9C, {25'h0, ~img});
         usbRst <= (k != 1);
         liteRst <= (k == 1);
         repeat (2) @(posedge mclk);
         usbRst <= 1'b0;
         liteRst <= 1'b0;
         busRd(8'h9C, {25'h0, img});
      end
      giveVerdict();
   end
endmodule // usb_irq_enable_and_wakeup_status_tb_top
